// >>> hdl/swc_ctrl.sv
// Mode, transmit guard, receive path and APB registers of the transceiver.
// Operation
// - Transmit input high leaves the bus undriven in every mode.
// - Transmit low drives dominant in the three active modes; high-voltage level in wake-up mode.
// - Sleep never drives the bus dominant.
// - Transmit pull-up on only in the three active modes.
// - Transmit low longer than 17 ms switches the bus driver off.
// - Next rising transmit edge re-enables the driver at once.
// - Both mode inputs carry weak pull-downs, defaulting to sleep.
// - Receive path blanked 0.5 to 6.0 us after each transmit rise.
// - Wake level must persist 10 to 70 us to count as wake-up.
// - Normal to or from high-speed or wake-up mode within 30 ms.
// - Normal to standby completes within 500 us.
// - Sleep to normal or wake-up mode completes within 50 ms.
// - Standby falls back to sleep after about 250 ms unchanged.
// - Outside sleep receive is high for recessive, low for dominant.
// - Valid wake drives receive low; sleep again after 250 ms.
// - Receive undriven in sleep; sleep ends on wake or mode change.
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module swc_ctrl #(
  parameter int DOM_TICKS   = swc_pkg::DOM_TIMEOUT_TICKS,
  parameter int STBY_TICKS  = swc_pkg::STBY_SLEEP_TICKS,
  parameter int WAKE_TICKS  = swc_pkg::WAKE_FILTER_TICKS,
  parameter int BLANK_CYC   = swc_pkg::BLANK_CYCLES
) (
  input  wire logic                      sys_clk_in,
  input  wire logic                      srst_in,
  input  wire logic                      tx_data_in,
  input  wire logic                      mode_sel_lo_in,
  input  wire logic                      mode_sel_hi_in,
  input  wire logic                      bus_line_in,
  input  wire logic                      high_voltage_wakeup_in,
  input  wire logic                      psel_in,
  input  wire logic                      penable_in,
  input  wire logic                      pwrite_in,
  input  wire logic [swc_pkg::APB_AW-1:0] paddr_in,
  input  wire logic [31:0]               pwdata_in,
  output logic                           bus_line_oe_out,
  output logic                           bus_line_hv_out,
  output logic                           tx_pullup_en_out,
  output logic                           mode_pulldown_en_out,
  output logic                           rx_data_out,
  output logic                           rx_data_oe_out,
  output logic                           regulator_enable_out,
  output logic                           irq_out,
  output logic [31:0]                    prdata_out,
  output logic                           pready_out,
  output logic                           pslverr_out
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  localparam int TMAX = 2 ** swc_pkg::TMR_W;
  if (DOM_TICKS < 1 || DOM_TICKS >= TMAX || STBY_TICKS < 1 ||
      STBY_TICKS >= TMAX || WAKE_TICKS < 1 || WAKE_TICKS >= TMAX ||
      BLANK_CYC < 1 || BLANK_CYC >= TMAX) begin : g_bad_param
    $error("swc_ctrl: timer limit out of range");
  end

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic tx_meta_ff, tx_sync_ff, tx_prev_ff;
  logic lo_meta_ff, lo_sync_ff, hi_meta_ff, hi_sync_ff;
  logic bus_meta_ff, bus_sync_ff, hv_meta_ff, hv_sync_ff;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      tx_meta_ff  <= 1'b1;
      tx_sync_ff  <= 1'b1;
      tx_prev_ff  <= 1'b1;
      lo_meta_ff  <= 1'b0;
      lo_sync_ff  <= 1'b0;
      hi_meta_ff  <= 1'b0;
      hi_sync_ff  <= 1'b0;
      bus_meta_ff <= 1'b0;
      bus_sync_ff <= 1'b0;
      hv_meta_ff  <= 1'b0;
      hv_sync_ff  <= 1'b0;
    end else begin
      tx_meta_ff  <= tx_data_in;
      tx_sync_ff  <= tx_meta_ff;
      tx_prev_ff  <= tx_sync_ff;
      lo_meta_ff  <= mode_sel_lo_in;
      lo_sync_ff  <= lo_meta_ff;
      hi_meta_ff  <= mode_sel_hi_in;
      hi_sync_ff  <= hi_meta_ff;
      bus_meta_ff <= bus_line_in;
      bus_sync_ff <= bus_meta_ff;
      hv_meta_ff  <= high_voltage_wakeup_in;
      hv_sync_ff  <= hv_meta_ff;
    end
  end

  logic                  tx_rise;
  swc_pkg::swc_state_type cmd;
  assign tx_rise = tx_sync_ff && !tx_prev_ff;
  assign cmd     = swc_pkg::swc_mode_of(lo_sync_ff, hi_sync_ff);

  // ************************************************************
  // Microsecond time base
  // ************************************************************
  logic [swc_pkg::TICK_W-1:0] tick_cnt_ff;
  logic                       tick_ff;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b0;
    end else if (tick_cnt_ff ==
                 swc_pkg::TICK_W'(swc_pkg::TICK_CYCLES - 1)) begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + swc_pkg::TICK_W'(1);
      tick_ff     <= 1'b0;
    end
  end

  // ************************************************************
  // Mode state machine
  // ************************************************************
  swc_pkg::swc_state_type state_ff, nxt_state;
  logic active, in_sleep;
  logic dom_done, stby_done, wake_done, blank_done;
  logic wake_en_ff, wake_flag_ff, nxt_wake_flag;

  assign in_sleep = (state_ff == swc_pkg::ST_SLEEP);
  assign active   = (state_ff == swc_pkg::ST_HSPEED) ||
                    (state_ff == swc_pkg::ST_HVWAKE) ||
                    (state_ff == swc_pkg::ST_NORMAL);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      swc_pkg::ST_SLEEP: begin
        if (cmd != swc_pkg::ST_SLEEP) begin
          nxt_state = cmd;
        end else if (wake_done) begin
          nxt_state = swc_pkg::ST_STANDBY;
        end
      end
      swc_pkg::ST_STANDBY: begin
        if (cmd != swc_pkg::ST_SLEEP) begin
          nxt_state = cmd;
        end else if (stby_done) begin
          nxt_state = swc_pkg::ST_SLEEP;
        end
      end
      swc_pkg::ST_HSPEED, swc_pkg::ST_HVWAKE, swc_pkg::ST_NORMAL: begin
        if (cmd == swc_pkg::ST_SLEEP) begin
          nxt_state = swc_pkg::ST_STANDBY;
        end else begin
          nxt_state = cmd;
        end
      end
      default: nxt_state = swc_pkg::ST_STANDBY;
    endcase
  end

  always_comb begin
    nxt_wake_flag = wake_flag_ff;
    if (in_sleep && cmd == swc_pkg::ST_SLEEP && wake_done) begin
      nxt_wake_flag = 1'b1;
    end else if (state_ff != swc_pkg::ST_STANDBY) begin
      nxt_wake_flag = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      state_ff     <= swc_pkg::ST_STANDBY;
      wake_flag_ff <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      wake_flag_ff <= nxt_wake_flag;
    end
  end

  // ************************************************************
  // Timers
  // ************************************************************
  // Tick-based timers may finish up to one tick early; all windows
  // are wide enough that this does not matter.
  swc_timer #(.W(swc_pkg::TMR_W)) u_dom_tmr (
    .sys_clk_in  (sys_clk_in),
    .srst_in     (srst_in),
    .restart_in  (tx_sync_ff || !active),
    .count_en_in (tick_ff),
    .limit_in    (swc_pkg::TMR_W'(DOM_TICKS)),
    .done_out    (dom_done)
  );
  swc_timer #(.W(swc_pkg::TMR_W)) u_stby_tmr (
    .sys_clk_in  (sys_clk_in),
    .srst_in     (srst_in),
    .restart_in  (state_ff != swc_pkg::ST_STANDBY),
    .count_en_in (tick_ff),
    .limit_in    (swc_pkg::TMR_W'(STBY_TICKS)),
    .done_out    (stby_done)
  );
  swc_timer #(.W(swc_pkg::TMR_W)) u_wake_tmr (
    .sys_clk_in  (sys_clk_in),
    .srst_in     (srst_in),
    .restart_in  (!in_sleep || !hv_sync_ff || !wake_en_ff),
    .count_en_in (tick_ff),
    .limit_in    (swc_pkg::TMR_W'(WAKE_TICKS)),
    .done_out    (wake_done)
  );
  swc_timer #(.W(swc_pkg::TMR_W)) u_blank_tmr (
    .sys_clk_in  (sys_clk_in),
    .srst_in     (srst_in),
    .restart_in  (tx_rise),
    .count_en_in (1'b1),
    .limit_in    (swc_pkg::TMR_W'(BLANK_CYC)),
    .done_out    (blank_done)
  );

  // ************************************************************
  // Transmit guard and pin drive
  // ************************************************************
  logic dom_lock_ff, blank_ff, lock_set;
  assign lock_set = dom_done && !tx_sync_ff && active;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      dom_lock_ff <= 1'b0;
      blank_ff    <= 1'b0;
    end else begin
      if (tx_rise) begin
        dom_lock_ff <= 1'b0;
      end else if (lock_set) begin
        dom_lock_ff <= 1'b1;
      end
      if (tx_rise && !in_sleep) begin
        blank_ff <= 1'b1;
      end else if (blank_done) begin
        blank_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      bus_line_oe_out      <= 1'b0;
      bus_line_hv_out      <= 1'b0;
      tx_pullup_en_out     <= 1'b0;
      mode_pulldown_en_out <= 1'b1;
      regulator_enable_out <= 1'b1;
    end else begin
      bus_line_oe_out      <= active && !tx_sync_ff && !dom_lock_ff;
      bus_line_hv_out      <= (state_ff == swc_pkg::ST_HVWAKE);
      tx_pullup_en_out     <= active;
      mode_pulldown_en_out <= 1'b1;
      regulator_enable_out <= !in_sleep;
    end
  end

  // ************************************************************
  // Receive path
  // ************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      rx_data_out    <= 1'b1;
      rx_data_oe_out <= 1'b1;
    end else begin
      rx_data_oe_out <= !in_sleep;
      if (in_sleep) begin
        rx_data_out <= 1'b1;
      end else if (wake_flag_ff) begin
        rx_data_out <= 1'b0;
      end else if (tx_rise || blank_ff) begin
        rx_data_out <= 1'b1;
      end else begin
        rx_data_out <= !bus_sync_ff;
      end
    end
  end

  // ************************************************************
  // APB registers and interrupt
  // ************************************************************
  logic [swc_pkg::EV_W-1:0] status_ff, enable_ff, events, clr;
  logic                     rd_phase, wr_fire, mapped;
  logic [31:0]              rd_mux;

  assign rd_phase = psel_in && penable_in && !pready_out;
  assign wr_fire  = psel_in && penable_in && pready_out && pwrite_in;
  assign events[swc_pkg::EV_DOM]   = lock_set && !dom_lock_ff;
  assign events[swc_pkg::EV_WAKE]  = nxt_wake_flag && !wake_flag_ff;
  assign events[swc_pkg::EV_SLEEP] = (nxt_state == swc_pkg::ST_SLEEP)
                                     && !in_sleep;
  assign events[swc_pkg::EV_MODE]  = (nxt_state != state_ff);
  assign clr = (wr_fire && paddr_in == swc_pkg::REG_CLEAR) ?
               pwdata_in[swc_pkg::EV_W-1:0] : '0;

  always_comb begin
    rd_mux = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr_in)
      swc_pkg::REG_STATUS: rd_mux[swc_pkg::EV_W-1:0] = status_ff;
      swc_pkg::REG_CLEAR:  rd_mux = 32'h0000_0000;
      swc_pkg::REG_ENABLE: rd_mux[swc_pkg::EV_W-1:0] = enable_ff;
      swc_pkg::REG_CTRL:   rd_mux[swc_pkg::CTRL_WAKE_EN] = wake_en_ff;
      swc_pkg::REG_STATE: begin
        rd_mux[4:0]                   = state_ff;
        rd_mux[swc_pkg::ST_TX_BIT]    = tx_sync_ff;
        rd_mux[swc_pkg::ST_LOCK_BIT]  = dom_lock_ff;
        rd_mux[swc_pkg::ST_WFLAG_BIT] = wake_flag_ff;
      end
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out <= rd_phase;
      if (rd_phase) begin
        pslverr_out <= !mapped;
        prdata_out  <= pwrite_in ? 32'h0000_0000 : rd_mux;
      end else begin
        pslverr_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      enable_ff  <= swc_pkg::ENABLE_RST;
      wake_en_ff <= swc_pkg::CTRL_RST;
    end else if (wr_fire && paddr_in == swc_pkg::REG_ENABLE) begin
      enable_ff <= pwdata_in[swc_pkg::EV_W-1:0];
    end else if (wr_fire && paddr_in == swc_pkg::REG_CTRL) begin
      wake_en_ff <= pwdata_in[swc_pkg::CTRL_WAKE_EN];
    end
  end

  // Set wins over clear so an event in the clearing cycle survives
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      status_ff <= '0;
      irq_out   <= 1'b0;
    end else begin
      status_ff <= (status_ff & ~clr) | events;
      irq_out   <= |(status_ff & enable_ff);
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_timeout_hit;
    dom_done && !tx_sync_ff && active;
  endsequence
  sequence s_bus_released;
    dom_lock_ff ##1 !bus_line_oe_out;
  endsequence

  AST_RECESSIVE_TX_HIGH: assert property (@(posedge sys_clk_in)
    disable iff (srst_in) tx_sync_ff |=> !bus_line_oe_out)
    else $error("bus driven while transmit input high");
  AST_DOMINANT_TX_LOW: assert property (@(posedge sys_clk_in)
    disable iff (srst_in)
    active && !tx_sync_ff && !dom_lock_ff |=> bus_line_oe_out)
    else $error("bus not driven for low transmit input");
  AST_HV_LEVEL: assert property (@(posedge sys_clk_in)
    disable iff (srst_in)
    bus_line_oe_out |-> bus_line_hv_out ==
                        $past(state_ff == swc_pkg::ST_HVWAKE))
    else $error("wrong dominant level for mode");
  AST_SLEEP_NO_DRIVE: assert property (@(posedge sys_clk_in)
    disable iff (srst_in) in_sleep |=> !bus_line_oe_out)
    else $error("bus driven in sleep");
  AST_PULLUP: assert property (@(posedge sys_clk_in)
    disable iff (srst_in) ##1 tx_pullup_en_out == $past(active))
    else $error("pull-up state does not follow mode");
  AST_DOM_TIMEOUT: assert property (@(posedge sys_clk_in)
    disable iff (srst_in) s_timeout_hit |=> s_bus_released)
    else $error("driver not released after timeout");
  AST_RELEASE: assert property (@(posedge sys_clk_in)
    disable iff (srst_in) dom_lock_ff && tx_rise |=> !dom_lock_ff)
    else $error("timeout lock not released on rising edge");
  AST_BLANK: assert property (@(posedge sys_clk_in)
    disable iff (srst_in) tx_rise && active |=> rx_data_out [*8])
    else $error("receive not blanked after transmit rise");
  AST_WAKE_ACCEPT: assert property (@(posedge sys_clk_in)
    disable iff (srst_in)
    in_sleep && cmd == swc_pkg::ST_SLEEP && wake_done |=>
      state_ff == swc_pkg::ST_STANDBY ##1 !rx_data_out)
    else $error("valid wake-up not taken or not indicated");
  AST_MODE_FOLLOW: assert property (@(posedge sys_clk_in)
    disable iff (srst_in)
    cmd != swc_pkg::ST_SLEEP |=> state_ff == $past(cmd))
    else $error("mode change not applied");
  AST_STANDBY_ENTRY: assert property (@(posedge sys_clk_in)
    disable iff (srst_in)
    active && cmd == swc_pkg::ST_SLEEP |=> state_ff == swc_pkg::ST_STANDBY)
    else $error("standby not entered");
  AST_STANDBY_TIMEOUT: assert property (@(posedge sys_clk_in)
    disable iff (srst_in)
    state_ff == swc_pkg::ST_STANDBY && cmd == swc_pkg::ST_SLEEP &&
    stby_done |=> in_sleep ##1 !regulator_enable_out)
    else $error("standby did not fall back to sleep");
  AST_RX_SLEEP_OFF: assert property (@(posedge sys_clk_in)
    disable iff (srst_in) in_sleep |=> !rx_data_oe_out)
    else $error("receive driven in sleep");
  AST_RX_FOLLOW: assert property (@(posedge sys_clk_in)
    disable iff (srst_in)
    !in_sleep && !wake_flag_ff && !blank_ff && !tx_rise |=>
      rx_data_out == !$past(bus_sync_ff))
    else $error("receive does not follow bus");

endmodule : swc_ctrl

// >>> hdl/swc_pkg.sv
// Constants, types and mode decode shared by the single-wire transceiver.
package swc_pkg;

  // ************************************************************
  // Time base
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_US       = TICK_NS / 1000;
  localparam int TICK_W        = $clog2(TICK_CYCLES);
  localparam int TMR_W         = 20;

  // ************************************************************
  // Timer figures
  // ************************************************************
  localparam int DOM_TIMEOUT_MS    = 17;
  localparam int DOM_TIMEOUT_TICKS = DOM_TIMEOUT_MS * 1000 / TICK_US;
  localparam int STBY_SLEEP_MS     = 250;
  localparam int STBY_SLEEP_TICKS  = STBY_SLEEP_MS * 1000 / TICK_US;
  // Chosen inside the 10 to 70 us window, with margin on both sides
  localparam int WAKE_FILTER_US    = 20;
  localparam int WAKE_FILTER_TICKS = (WAKE_FILTER_US + TICK_US - 1) / TICK_US;
  // Chosen inside the 0.5 to 6.0 us window
  localparam int BLANK_NS          = 3000;
  localparam int BLANK_CYCLES      = (BLANK_NS + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int             APB_AW     = 8;
  localparam logic [7:0]     REG_STATUS = 8'h00;
  localparam logic [7:0]     REG_CLEAR  = 8'h04;
  localparam logic [7:0]     REG_ENABLE = 8'h08;
  localparam logic [7:0]     REG_CTRL   = 8'h0C;
  localparam logic [7:0]     REG_STATE  = 8'h10;
  localparam int             EV_W       = 4;
  localparam int             EV_DOM     = 0;
  localparam int             EV_WAKE    = 1;
  localparam int             EV_SLEEP   = 2;
  localparam int             EV_MODE    = 3;
  localparam logic [3:0]     ENABLE_RST = 4'h0;
  localparam int             CTRL_WAKE_EN = 0;
  localparam logic           CTRL_RST   = 1'b1;
  localparam int             ST_TX_BIT  = 8;
  localparam int             ST_LOCK_BIT = 9;
  localparam int             ST_WFLAG_BIT = 10;

  // ************************************************************
  // Operating states
  // ************************************************************
  typedef enum logic [4:0] {
    ST_SLEEP   = 5'h01,
    ST_STANDBY = 5'h02,
    ST_HSPEED  = 5'h04,
    ST_HVWAKE  = 5'h08,
    ST_NORMAL  = 5'h10
  } swc_state_type;

  function automatic swc_state_type swc_mode_of(input logic lo,
                                                input logic hi);
    swc_state_type m;
    case ({lo, hi})
      2'b00:   m = ST_SLEEP;
      2'b10:   m = ST_HSPEED;
      2'b01:   m = ST_HVWAKE;
      2'b11:   m = ST_NORMAL;
      default: m = ST_SLEEP;
    endcase
    return m;
  endfunction : swc_mode_of

endpackage : swc_pkg

// >>> hdl/swc_timer.sv
// Restartable up-counter that flags when a limit of enabled steps is hit.
`timescale 1ns/1ns
module swc_timer #(
  parameter int W = 20
) (
  input  wire logic         sys_clk_in,
  input  wire logic         srst_in,
  input  wire logic         restart_in,
  input  wire logic         count_en_in,
  input  wire logic [W-1:0] limit_in,
  output logic              done_out
);
  logic [W-1:0] cnt_ff;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in || restart_in) begin
      cnt_ff   <= '0;
      done_out <= 1'b0;
    end else if (count_en_in && !done_out) begin
      cnt_ff <= cnt_ff + W'(1);
      if (cnt_ff == limit_in - W'(1)) begin
        done_out <= 1'b1;
      end
    end
  end
endmodule : swc_timer

// >>> tb/swc_host_model.sv
// Controller-side model that drives the transmit and mode pins.
`timescale 1ns/1ns
module swc_host_model (
  input  wire logic       sys_clk_in,
  input  wire logic [1:0] mode_cmd_in,
  input  wire logic       tx_cmd_in,
  output logic            tx_data_out = 1'b1,
  output logic            mode_sel_lo_out = 1'b0,
  output logic            mode_sel_hi_out = 1'b0
);
  // ************************************************************
  // Pin drive
  // ************************************************************
  // Pins move just after a rising edge, like a real port register
  always_ff @(posedge sys_clk_in) begin
    tx_data_out <= tx_cmd_in;
    {mode_sel_lo_out, mode_sel_hi_out} <= mode_cmd_in;
  end
endmodule : swc_host_model

// >>> tb/testbench.sv
// Self-checking bench for the single-wire transceiver control block.
`timescale 1ns/1ns
module testbench;
  localparam int DOM   = 20;
  localparam int STBY  = 30;
  localparam int WAKE  = 3;
  localparam int BLANK = 8;
  localparam int TK    = swc_pkg::TICK_CYCLES;
  logic        clk      = 1'b0;
  logic        srst     = 1'b1;
  logic [1:0]  mode_cmd = 2'h0;
  logic        tx_cmd   = 1'b1;
  logic        ext_dom  = 1'b0;
  logic        ext_hv   = 1'b0;
  logic        psel     = 1'b0;
  logic        pen      = 1'b0;
  logic        pwr      = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic        tx, m_lo, m_hi, oe, hv, pu, pd, rx, rx_oe, reg_en, irq;
  logic        pready, pslverr, err;
  logic [31:0] prdata, rd, r;
  logic [4:0]  st_of [4] = '{5'h02, 5'h08, 5'h04, 5'h10};
  int          n_mismatch = 0;
  int          n_tests    = 0;

  swc_host_model u_host (.sys_clk_in(clk), .mode_cmd_in(mode_cmd),
    .tx_cmd_in(tx_cmd), .tx_data_out(tx), .mode_sel_lo_out(m_lo),
    .mode_sel_hi_out(m_hi));
  // Bus is a wired-or of this node, another node and a wake sender
  swc_ctrl #(.DOM_TICKS(DOM), .STBY_TICKS(STBY), .WAKE_TICKS(WAKE),
    .BLANK_CYC(BLANK)) u_dut (.sys_clk_in(clk), .srst_in(srst),
    .tx_data_in(tx), .mode_sel_lo_in(m_lo), .mode_sel_hi_in(m_hi),
    .bus_line_in(oe | ext_dom | ext_hv),
    .high_voltage_wakeup_in((oe & hv) | ext_hv), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .bus_line_oe_out(oe), .bus_line_hv_out(hv),
    .tx_pullup_en_out(pu), .mode_pulldown_en_out(pd),
    .rx_data_out(rx), .rx_data_oe_out(rx_oe),
    .regulator_enable_out(reg_en), .irq_out(irq), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr));

  initial begin
    forever #5 clk = ~clk;
  end

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic set_mode(input logic [1:0] m);
    mode_cmd <= m;
    cyc(10);
  endtask : set_mode

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    // No cycle count is assumed here: only the watchdog ends a stuck wait
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    r = $urandom(27686);
    r = $urandom();
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    cyc(1);
    chk({reg_en, pd}, 2'h3);
    apb(1'b0, swc_pkg::REG_STATE, 32'h0);
    chk(rd[4:0], 5'h02);
    for (int i = 3; i >= 0; i--) begin
      set_mode(i[1:0]);
      apb(1'b0, swc_pkg::REG_STATE, 32'h0);
      chk(rd[4:0], st_of[i]);
      chk(pu, i > 0);
    end
    cyc(STBY * TK - 300);
    apb(1'b0, swc_pkg::REG_STATE, 32'h0);
    chk(rd[4:0], 5'h02);
    cyc(400);
    apb(1'b0, swc_pkg::REG_STATE, 32'h0);
    chk(rd[4:0], 5'h01);
    chk({rx_oe, reg_en, pu}, 3'h0);
    tx_cmd <= 1'b0;
    cyc(10);
    chk(oe, 1'h0);
    tx_cmd <= 1'b1;
    apb(1'b1, swc_pkg::REG_ENABLE, {r[31:4], 4'h2});
    apb(1'b0, swc_pkg::REG_ENABLE, 32'h0);
    chk(rd, 32'h2);
    ext_hv <= 1'b1;
    cyc(TK);
    ext_hv <= 1'b0;
    cyc(20);
    chk(rx_oe, 1'h0);
    apb(1'b1, swc_pkg::REG_CTRL, 32'h0);
    apb(1'b0, swc_pkg::REG_CTRL, 32'h0);
    chk(rd, 32'h0);
    ext_hv <= 1'b1;
    cyc(WAKE * TK + 50);
    chk({rx_oe, reg_en}, 2'h0);
    apb(1'b1, swc_pkg::REG_CTRL, 32'h1);
    ext_hv <= 1'b1;
    cyc(WAKE * TK + 50);
    chk({rx_oe, rx, reg_en}, 3'h5);
    ext_hv <= 1'b0;
    cyc(10);
    chk({rx, irq}, 2'h1);
    apb(1'b1, swc_pkg::REG_CLEAR, 32'h2);
    cyc(3);
    chk(irq, 1'h0);
    cyc(STBY * TK + 200);
    chk({reg_en, rx_oe}, 2'h0);
    set_mode(2'h3);
    apb(1'b0, swc_pkg::REG_STATE, 32'h0);
    chk(rd[4:0], 5'h10);
    tx_cmd <= 1'b0;
    cyc(6);
    chk({oe, hv}, 2'h2);
    tx_cmd <= 1'b1;
    ext_dom <= 1'b1;
    cyc(6);
    chk({oe, rx}, 2'h1);
    cyc(BLANK + 20);
    chk(rx, 1'h0);
    ext_dom <= 1'b0;
    cyc(10);
    chk(rx, 1'h1);
    set_mode(2'h1);
    tx_cmd <= 1'b0;
    cyc(6);
    chk({oe, hv}, 2'h3);
    cyc(DOM * TK - 200);
    chk(oe, 1'h1);
    cyc(400);
    chk(oe, 1'h0);
    apb(1'b0, swc_pkg::REG_STATUS, 32'h0);
    chk(rd[0], 1'h1);
    tx_cmd <= 1'b1;
    cyc(3);
    tx_cmd <= 1'b0;
    cyc(6);
    chk(oe, 1'h1);
    tx_cmd <= 1'b1;
    apb(1'b0, 8'h20, 32'h0);
    chk(err, 1'h1);
    tally_and_finish();
  end

  initial begin
    #300000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule : testbench
